/* File: design/fppt_pkg.sv */
package fppt_pkg;

  // Register file addresses
  localparam logic [7:0] ADDR_CMD    = 8'h01;
  localparam logic [7:0] ADDR_PAGE   = 8'h02;
  localparam logic [7:0] ADDR_KHZ_HI = 8'h03;
  localparam logic [7:0] ADDR_KHZ_LO = 8'h04;

  // Command values written to the command register
  localparam logic [7:0] CMD_UNLOCK1    = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2    = 8'h8c;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_GUARD_SEL  = 8'h5e;

  // Page select layout
  localparam int         INFO_BIT      = 7;
  localparam int         PAGE_W        = 7;
  localparam logic [7:0] INFO_PAGE_SEL = 8'h83;
  localparam int         MAIN_PAGE_LSB = 9;
  localparam int         INFO_PAGE_LSB = 6;
  localparam int         SECTOR_LSB    = 4;
  localparam int         SECTOR_W      = 3;
  localparam int         SMALL_SECTORS = 4;

  // Reset values
  localparam logic [7:0] PAGE_RESET  = 8'h00;
  localparam logic [7:0] GUARD_RESET = 8'h00;
  localparam logic [7:0] KHZ_RESET   = 8'h00;

  // Controller state field codes
  localparam logic [5:0] ST_LOCKED    = 6'h00;
  localparam logic [5:0] ST_FIRST     = 6'h01;
  localparam logic [5:0] ST_UNLOCKED  = 6'h03;
  localparam logic [5:0] ST_GUARD_SEL = 6'h04;
  localparam logic [5:0] ST_PROGRAM   = 6'h08;
  localparam logic [5:0] ST_ERASE     = 6'h10;

  // Timing, scaled by the kHz value
  localparam int          DUR_W         = 14;
  localparam int          PROG_TIME_US  = 30;
  localparam int          ERASE_TIME_MS = 10;
  localparam int          US_PER_MS     = 1000;
  localparam int          ERASE_TIME_US = ERASE_TIME_MS * US_PER_MS;
  localparam logic [16:0] KHZ_PER_MHZ   = 17'h0_03e8;

  typedef enum logic [2:0] {
    S_LOCKED, S_FIRST, S_UNLOCKED, S_GUARD_SEL, S_PROGRAM, S_ERASE
  } fppt_state_type;

  // Register file access from either initiator
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       from_port;
  } fppt_reg_req_type;

  // Byte program request
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        from_port;
  } fppt_prog_req_type;

endpackage

/* File: design/fppt_timer.sv */
`timescale 1ns/1ps
module fppt_timer #(
  parameter int DUR_W = 14
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             start,
  input  wire logic [DUR_W-1:0] dur_us,
  input  wire logic [15:0]      khz,
  // Status
  output logic                  busy,
  output logic                  done
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [15:0]      acc;
    logic [DUR_W-1:0] left;
  } fppt_timer_state_type;

  fppt_timer_state_type st_ff;
  fppt_timer_state_type nxt_st;
  logic [16:0]          acc_sum;
  logic                 us_tick;

  // Fractional divider: 1000 per cycle against kHz gives one tick per microsecond
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    acc_sum = {1'b0, st_ff.acc} + fppt_pkg::KHZ_PER_MHZ;
    us_tick = acc_sum >= {1'b0, khz};
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.acc = 16'h0000;
      nxt_st.left = dur_us;
    end else if (st_ff.busy) begin
      if (us_tick) begin
        // Below 1 MHz the clock is unsupported; keep the accumulator bounded
        nxt_st.acc = (khz >= fppt_pkg::KHZ_PER_MHZ[15:0]) ? 16'(acc_sum - {1'b0, khz}) : 16'h0000;
        if (st_ff.left <= DUR_W'(1)) begin
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
        end else begin
          nxt_st.left = st_ff.left - DUR_W'(1);
        end
      end else begin
        nxt_st.acc = acc_sum[15:0];
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;

endmodule // fppt_timer

/* File: design/fppt_ctrl.sv */
// Notes on behaviour
// - Shared address goes to guard after 5EH.
// - Top page bit selects main or info.
// - Main erase clears page addr[15:9].
// - Main program needs addr[15:9] match.
// - CPU info-area program or erase ignored.
// - Info operations need page select 83H.
// - Info program needs addr[12:6] match.
// - Guard bit blocks CPU ops in sector.
// - Port operations ignore all guard bits.
// - Guard bits reset zero, stick once set.
// - Small variant uses low four guard bits.
// - Two bytes form kHz timing value.
// - Program about 30 us, erase 10 ms.
// - Track initiator of each page erase and program request.
// - Unlock needs 73H then 8CH.
// - Invalid command returns to locked.
// - 95H third write erases selected page.
`timescale 1ns/1ps
module fppt_ctrl #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int PROG_US       = fppt_pkg::PROG_TIME_US,
  parameter int ERASE_US      = fppt_pkg::ERASE_TIME_US
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Register file access
  input  fppt_pkg::fppt_reg_req_type       reg_req,
  output logic [7:0]                       reg_rdata,
  // Byte program request
  input  fppt_pkg::fppt_prog_req_type      prog_req,
  // Flash array control
  output logic                             flash_prog,
  output logic                             flash_erase,
  output logic                             flash_info,
  output logic [15:0]                      flash_addr,
  output logic [7:0]                       flash_data,
  // Operation status
  output logic                             op_from_port,
  output logic                             op_done,
  output logic                             op_rejected
);

  typedef struct packed {
    fppt_pkg::fppt_state_type st;
    logic [7:0]               page;
    logic [7:0]               guard;
    logic [7:0]               khz_hi;
    logic [7:0]               khz_lo;
    logic [7:0]               rdata;
    logic                     prog;
    logic                     erase;
    logic                     info;
    logic [15:0]              faddr;
    logic [7:0]               fdata;
    logic                     from_port;
    logic                     start;
    logic [fppt_pkg::DUR_W-1:0] dur;
    logic                     done;
    logic                     reject;
  } fppt_ctrl_state_type;

  fppt_ctrl_state_type st_ff;
  fppt_ctrl_state_type nxt_st;
  logic [7:0]          guard_eff;
  logic [15:0]         khz;
  logic                tmr_done;
  logic                tmr_busy;
  logic                cmd_wr;
  logic                page_wr;
  logic                erase_ok;
  logic                prog_ok;

  // Small variant drops the upper four sectors from the check
  // sector bit masking
  for (genvar i = 0; i < 8; i++) begin : g_guard
    assign guard_eff[i] = st_ff.guard[i] & (LARGE_VARIANT | (i < fppt_pkg::SMALL_SECTORS));
  end

  assign khz = {st_ff.khz_hi, st_ff.khz_lo};

  // Permission check shared by program and page erase
  function automatic logic op_allowed(input logic        is_erase,
                                      input logic        from_port,
                                      input logic [15:0] addr,
                                      input logic [7:0]  page,
                                      input logic [7:0]  geff);
    logic [6:0] pg;
    logic       ok;
    pg = page[fppt_pkg::PAGE_W-1:0];
    ok = 1'b0;
    if (page[fppt_pkg::INFO_BIT]) begin
      ok = from_port && (page == fppt_pkg::INFO_PAGE_SEL);
      if (!is_erase && (addr[fppt_pkg::INFO_PAGE_LSB +: fppt_pkg::PAGE_W] != pg)) begin
        ok = 1'b0;
      end
    end else begin
      if (!is_erase) begin
        pg = addr[fppt_pkg::MAIN_PAGE_LSB +: fppt_pkg::PAGE_W];
        ok = (pg == page[fppt_pkg::PAGE_W-1:0]);
      end else begin
        ok = 1'b1;
      end
      if (!from_port && geff[pg[fppt_pkg::SECTOR_LSB +: fppt_pkg::SECTOR_W]]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Status field encoding of the controller state
  function automatic logic [5:0] state_code(input fppt_pkg::fppt_state_type s);
    logic [5:0] c;
    c = fppt_pkg::ST_LOCKED;
    case (s)
      fppt_pkg::S_FIRST:     c = fppt_pkg::ST_FIRST;
      fppt_pkg::S_UNLOCKED:  c = fppt_pkg::ST_UNLOCKED;
      fppt_pkg::S_GUARD_SEL: c = fppt_pkg::ST_GUARD_SEL;
      fppt_pkg::S_PROGRAM:   c = fppt_pkg::ST_PROGRAM;
      fppt_pkg::S_ERASE:     c = fppt_pkg::ST_ERASE;
      default:               c = fppt_pkg::ST_LOCKED;
    endcase
    return c;
  endfunction

  assign cmd_wr   = reg_req.wr && (reg_req.addr == fppt_pkg::ADDR_CMD);
  assign page_wr  = reg_req.wr && (reg_req.addr == fppt_pkg::ADDR_PAGE);
  assign erase_ok = op_allowed(1'b1, reg_req.from_port, 16'h0000, st_ff.page, guard_eff);
  assign prog_ok  = op_allowed(1'b0, prog_req.from_port, prog_req.addr, st_ff.page, guard_eff);

  // Duration timer, one microsecond tick derived from the kHz value
  // kHz scaled cycle count
  fppt_timer #(
    .DUR_W  (fppt_pkg::DUR_W)
  ) u_timer (
    .clk    (clk),
    .reset  (reset),
    .start  (st_ff.start),
    .dur_us (st_ff.dur),
    .khz    (khz),
    .busy   (tmr_busy),
    .done   (tmr_done)
  );

  // Next state: kHz bytes first, then command, program and timer traffic, then page select and read data
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.reject = 1'b0;
    // Frequency bytes are plain storage; software loads kHz before use
    if (reg_req.wr && reg_req.addr == fppt_pkg::ADDR_KHZ_HI) begin
      nxt_st.khz_hi = reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == fppt_pkg::ADDR_KHZ_LO) begin
      nxt_st.khz_lo = reg_req.wdata;
    end
    case (st_ff.st)
      fppt_pkg::S_LOCKED: begin
        if (cmd_wr && reg_req.wdata == fppt_pkg::CMD_UNLOCK1) begin
          nxt_st.st = fppt_pkg::S_FIRST;
        end else if (cmd_wr && reg_req.wdata == fppt_pkg::CMD_GUARD_SEL) begin
          nxt_st.st = fppt_pkg::S_GUARD_SEL;
        end
      end
      fppt_pkg::S_FIRST: begin
        if (cmd_wr) begin
          nxt_st.st = (reg_req.wdata == fppt_pkg::CMD_UNLOCK2) ? fppt_pkg::S_UNLOCKED : fppt_pkg::S_LOCKED;
        end
      end
      fppt_pkg::S_UNLOCKED: begin
        if (cmd_wr && reg_req.wdata == fppt_pkg::CMD_PAGE_ERASE) begin
          nxt_st.from_port = reg_req.from_port;
          if (erase_ok) begin
            nxt_st.st = fppt_pkg::S_ERASE;
            nxt_st.erase = 1'b1;
            nxt_st.info = st_ff.page[fppt_pkg::INFO_BIT];
            nxt_st.faddr = st_ff.page[fppt_pkg::INFO_BIT] ?
                           {3'b000, st_ff.page[fppt_pkg::PAGE_W-1:0], 6'b00_0000} :
                           {st_ff.page[fppt_pkg::PAGE_W-1:0], 9'h000};
            nxt_st.start = 1'b1;
            nxt_st.dur = fppt_pkg::DUR_W'(ERASE_US);
          end else begin
            nxt_st.st = fppt_pkg::S_LOCKED;
            nxt_st.reject = 1'b1;
          end
        end else if (cmd_wr) begin
          nxt_st.st = fppt_pkg::S_LOCKED;
        end else if (prog_req.valid) begin
          nxt_st.from_port = prog_req.from_port;
          if (prog_ok) begin
            nxt_st.st = fppt_pkg::S_PROGRAM;
            nxt_st.prog = 1'b1;
            nxt_st.info = st_ff.page[fppt_pkg::INFO_BIT];
            nxt_st.faddr = prog_req.addr;
            nxt_st.fdata = prog_req.data;
            nxt_st.start = 1'b1;
            nxt_st.dur = fppt_pkg::DUR_W'(PROG_US);
          end else begin
            nxt_st.reject = 1'b1;
          end
        end
      end
      fppt_pkg::S_GUARD_SEL: begin
        if (page_wr) begin
          nxt_st.guard = st_ff.guard | reg_req.wdata;
          nxt_st.st = fppt_pkg::S_LOCKED;
        end else if (cmd_wr) begin
          nxt_st.st = fppt_pkg::S_LOCKED;
        end
      end
      fppt_pkg::S_PROGRAM: begin
        // Controller stays unlocked so further bytes can follow
        if (tmr_done) begin
          nxt_st.st = fppt_pkg::S_UNLOCKED;
          nxt_st.prog = 1'b0;
          nxt_st.done = 1'b1;
        end
      end
      fppt_pkg::S_ERASE: begin
        if (tmr_done) begin
          nxt_st.st = fppt_pkg::S_LOCKED;
          nxt_st.erase = 1'b0;
          nxt_st.done = 1'b1;
        end
      end
      default: nxt_st.st = fppt_pkg::S_LOCKED;
    endcase
    // page select unless guard armed; frozen while an operation runs
    if (page_wr && st_ff.st != fppt_pkg::S_GUARD_SEL && !st_ff.prog && !st_ff.erase) begin
      nxt_st.page = reg_req.wdata;
    end
    // Read data; the shared address shows the guard while it is armed
    nxt_st.rdata = 8'h00;
    if (reg_req.rd) begin
      if (reg_req.addr == fppt_pkg::ADDR_CMD) begin
        nxt_st.rdata = {2'b00, state_code(st_ff.st)};
      end else if (reg_req.addr == fppt_pkg::ADDR_PAGE) begin
        nxt_st.rdata = (st_ff.st == fppt_pkg::S_GUARD_SEL) ? st_ff.guard : st_ff.page;
      end else if (reg_req.addr == fppt_pkg::ADDR_KHZ_HI) begin
        nxt_st.rdata = st_ff.khz_hi;
      end else if (reg_req.addr == fppt_pkg::ADDR_KHZ_LO) begin
        nxt_st.rdata = st_ff.khz_lo;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.st <= fppt_pkg::S_LOCKED;
      st_ff.page <= fppt_pkg::PAGE_RESET;
      st_ff.guard <= fppt_pkg::GUARD_RESET;
      st_ff.khz_hi <= fppt_pkg::KHZ_RESET;
      st_ff.khz_lo <= fppt_pkg::KHZ_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata    = st_ff.rdata;
  assign flash_prog   = st_ff.prog;
  assign flash_erase  = st_ff.erase;
  assign flash_info   = st_ff.info;
  assign flash_addr   = st_ff.faddr;
  assign flash_data   = st_ff.fdata;
  assign op_from_port = st_ff.from_port;
  assign op_done      = st_ff.done;
  assign op_rejected  = st_ff.reject;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  guard_sticky_a: assert property ((st_ff.guard & $past(st_ff.guard)) == $past(st_ff.guard))
    else $error("guard bit cleared");

  page_route_a: assert property (page_wr && st_ff.st == fppt_pkg::S_UNLOCKED |=> st_ff.page == $past(reg_req.wdata))
    else $error("page write lost");
  guard_route_a: assert property (page_wr && st_ff.st == fppt_pkg::S_GUARD_SEL |=> $stable(st_ff.page)
                                  && st_ff.guard == ($past(st_ff.guard) | $past(reg_req.wdata)))
    else $error("guard write misrouted");

  // unlock pair
  // A finished program also re-enters unlocked, so that path is told apart
  unlock_seq_a: assert property (st_ff.st == fppt_pkg::S_UNLOCKED && $changed(st_ff.st) |->
                                 ($past(st_ff.st) == fppt_pkg::S_FIRST && $past(cmd_wr)
                                  && $past(reg_req.wdata) == fppt_pkg::CMD_UNLOCK2)
                                 || ($past(st_ff.st) == fppt_pkg::S_PROGRAM && $past(tmr_done)))
    else $error("unlocked without sequence");

  bad_cmd_lock_a: assert property (cmd_wr && st_ff.st == fppt_pkg::S_FIRST && reg_req.wdata != fppt_pkg::CMD_UNLOCK2
                                   |=> st_ff.st == fppt_pkg::S_LOCKED)
    else $error("invalid command kept unlock");

  cpu_info_block_a: assert property (st_ff.st == fppt_pkg::S_UNLOCKED && prog_req.valid && !cmd_wr
                                     && !prog_req.from_port && st_ff.page[fppt_pkg::INFO_BIT]
                                     |=> op_rejected && !flash_prog)
    else $error("cpu info program accepted");

  main_page_match_a: assert property ($rose(flash_prog) && !flash_info |->
                                      flash_addr[15:9] == st_ff.page[6:0])
    else $error("program outside page");

  erase_page_a: assert property ($rose(flash_erase) && !flash_info |-> flash_addr == {st_ff.page[6:0], 9'h000})
    else $error("erase on wrong page");

  info_sel_a: assert property (($rose(flash_prog) || $rose(flash_erase)) && flash_info |->
                               st_ff.page == fppt_pkg::INFO_PAGE_SEL && op_from_port)
    else $error("info op without 83H");

  port_guard_a: assert property (st_ff.st == fppt_pkg::S_UNLOCKED && prog_req.valid && !cmd_wr && prog_req.from_port
                                 && !st_ff.page[fppt_pkg::INFO_BIT] && prog_req.addr[15:9] == st_ff.page[6:0]
                                 |=> flash_prog ##1 (flash_prog && tmr_busy))
    else $error("port program refused");

  prog_dur_a: assert property ($rose(flash_prog) |-> st_ff.start && st_ff.dur == fppt_pkg::DUR_W'(PROG_US))
    else $error("program duration wrong");

  unlock_c: cover property (st_ff.st == fppt_pkg::S_FIRST ##[1:20] st_ff.st == fppt_pkg::S_UNLOCKED);
  prog_done_c: cover property ($rose(flash_prog) ##[1:1000] op_done);
  guard_set_c: cover property (st_ff.st == fppt_pkg::S_GUARD_SEL ##1 st_ff.guard != 8'h00);
  reject_c: cover property (op_rejected);

endmodule // fppt_ctrl

/* File: dv/fppt_host_model.sv */
`timescale 1ns/1ps
module fppt_host_model (
  // Clock
  input  wire logic                   clk,
  // Requests toward the controller
  output fppt_pkg::fppt_reg_req_type  reg_req,
  output fppt_pkg::fppt_prog_req_type prog_req,
  // Read answer
  input  wire logic [7:0]             reg_rdata
);
  // Quiet buses at time zero
  initial begin
    reg_req  = '0;
    prog_req = '0;
  end

  // One register access; payload flips on release so stale bytes never look current
  // initiator flag
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        input logic port, output logic [7:0] rdata);
    @(posedge clk);
    reg_req <= '{wr, !wr, addr, data, port};
    @(posedge clk);
    reg_req <= '{1'b0, 1'b0, ~addr, ~data, ~port};
    @(negedge clk);
    rdata = reg_rdata;
  endtask

  // One byte program request, held for exactly one taking edge
  task automatic prog(input logic [15:0] addr, input logic [7:0] data, input logic port);
    @(posedge clk);
    prog_req <= '{1'b1, addr, data, port};
    @(posedge clk);
    prog_req <= '{1'b0, ~addr, ~data, ~port};
  endtask
endmodule // fppt_host_model

/* File: dv/flash_page_protect_timing_tb.sv */
`timescale 1ns/1ps
module flash_page_protect_timing_tb;
  // Short durations keep the run small; one tick per cycle at 1000 kHz
  localparam int PROG_US  = 3;
  localparam int ERASE_US = 20;

  logic                        clk;
  logic                        reset;
  fppt_pkg::fppt_reg_req_type  reg_req;
  fppt_pkg::fppt_prog_req_type prog_req;
  logic [7:0]                  reg_rdata;
  logic [7:0]                  flash_data;
  logic [15:0]                 flash_addr;
  logic                        flash_prog, flash_erase, flash_info;
  logic                        op_from_port, op_done, op_rejected;
  int                          fail_count;
  int                          samples_checked;
  logic [31:0]                 rng;
  logic [7:0]                  rd_val;
  logic [7:0]                  page_m;
  logic [7:0]                  guard_m;
  logic                        unl_m;

  // Operation table: page, erase, from port, byte address
  // info pages keep upper bits zero
  localparam logic [25:0] OPS [15] = '{
    {8'h05, 1'b0, 1'b0, 16'h0a10}, {8'h05, 1'b0, 1'b0, 16'h0c00}, {8'h05, 1'b0, 1'b1, 16'h0c00},
    {8'h70, 1'b0, 1'b0, 16'he000}, {8'h70, 1'b0, 1'b1, 16'he000}, {8'h70, 1'b1, 1'b0, 16'h0000},
    {8'h70, 1'b1, 1'b1, 16'h0000}, {8'h05, 1'b1, 1'b0, 16'h0000}, {8'h83, 1'b0, 1'b0, 16'h00c0},
    {8'h83, 1'b0, 1'b1, 16'h00c5}, {8'h83, 1'b0, 1'b1, 16'h0105}, {8'h83, 1'b1, 1'b0, 16'h0000},
    {8'h83, 1'b1, 1'b1, 16'h0000}, {8'h82, 1'b1, 1'b1, 16'h0000}, {8'h82, 1'b0, 1'b1, 16'h0080}};

  // Device under test
  fppt_ctrl #(.LARGE_VARIANT(1'b1), .PROG_US(PROG_US), .ERASE_US(ERASE_US)) u_dut (
    .clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .prog_req(prog_req),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_info(flash_info),
    .flash_addr(flash_addr), .flash_data(flash_data), .op_from_port(op_from_port),
    .op_done(op_done), .op_rejected(op_rejected));

  // Initiators on the far side
  fppt_host_model u_host (.clk(clk), .reg_req(reg_req), .prog_req(prog_req), .reg_rdata(reg_rdata));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (50000) @(posedge clk);
    check(16'h0001, 16'h0000);
    complete_run();
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Reference permission model from page, guard and initiator
  function automatic logic allowed(input logic erase, input logic port, input logic [15:0] addr);
    logic [2:0] sec;
    sec = erase ? page_m[6:4] : addr[15:13];
    if (page_m[7]) begin
      return port && page_m == 8'h83 && (erase || addr[12:6] == page_m[6:0]);
    end
    return (erase || addr[15:9] == page_m[6:0]) && (port || !guard_m[sec]);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
    u_host.access(1'b1, a, d, p, rd_val);
  endtask

  task automatic rd(input logic [7:0] a);
    u_host.access(1'b0, a, 8'h00, 1'b0, rd_val);
  endtask

  // Unlock when needed, launch one operation, follow it to its end
  task automatic run_op(input logic erase, input logic port, input logic [15:0] addr);
    logic       ok;
    logic [7:0] d;
    int         n;
    int         p;
    ok = allowed(erase, port, addr);
    d = rng[7:0];
    rng = xs(rng);
    p = erase ? ERASE_US : PROG_US;
    // Already unlocked: 95H follows directly, a fresh 73H would relock
    if (!unl_m) begin
      wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_UNLOCK1, port);
      wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_UNLOCK2, port);
      rd(fppt_pkg::ADDR_CMD);
      check(rd_val, 16'h0003);
    end
    if (erase) begin
      wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_PAGE_ERASE, port);
    end else begin
      u_host.prog(addr, d, port);
      @(negedge clk);
    end
    check(op_from_port, port);
    check(op_rejected, !ok);
    check(erase ? flash_erase : flash_prog, ok);
    if (ok) begin
      check(flash_info, page_m[7]);
      check(flash_addr, erase ? (page_m[7] ? {3'b000, page_m[6:0], 6'h00} : {page_m[6:0], 9'h000}) : addr);
      check(erase ? 8'h00 : flash_data, erase ? 8'h00 : d);
      n = 1;
      while (op_done !== 1'b1 && n < 2000) begin
        @(negedge clk);
        n++;
      end
      check(op_done, 16'h0001);
      // A timed-out operation ends the run
      if (op_done !== 1'b1) begin
        complete_run();
      end
      check(n >= p - 1 && n <= p + 3, 16'h0001);
    end
    unl_m = !erase;
    rd(fppt_pkg::ADDR_CMD);
    check(rd_val, erase ? 16'h0000 : 16'h0003);
  endtask

  // Main sequence
  initial begin
    logic [7:0] c;
    reset = 1'b1;
    fail_count = 0;
    samples_checked = 0;
    rng = 32'h0000_619a;
    page_m = 8'h00;
    guard_m = 8'h00;
    unl_m = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int a = 1; a <= 4; a++) begin
      rd(8'(a));
      check(rd_val, 16'h0000);
    end
    wr(fppt_pkg::ADDR_KHZ_HI, 8'h03, 1'b0);
    wr(fppt_pkg::ADDR_KHZ_LO, 8'he8, 1'b0);
    rd(fppt_pkg::ADDR_KHZ_HI);
    check(rd_val, 16'h0003);
    rd(fppt_pkg::ADDR_KHZ_LO);
    check(rd_val, 16'h00e8);
    // Arm guard access, protect the top sector, then try to clear it
    wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_GUARD_SEL, 1'b0);
    rd(fppt_pkg::ADDR_CMD);
    check(rd_val, 16'h0004);
    wr(fppt_pkg::ADDR_PAGE, 8'h80, 1'b0);
    guard_m = 8'h80;
    rd(fppt_pkg::ADDR_PAGE);
    check(rd_val, 16'h0000);
    wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_GUARD_SEL, 1'b0);
    wr(fppt_pkg::ADDR_PAGE, 8'h00, 1'b0);
    wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_GUARD_SEL, 1'b0);
    rd(fppt_pkg::ADDR_PAGE);
    check(rd_val, guard_m);
    wr(fppt_pkg::ADDR_CMD, 8'h00, 1'b0);
    // Broken unlock sequences fall back to locked
    wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_UNLOCK2, 1'b0);
    rd(fppt_pkg::ADDR_CMD);
    check(rd_val, 16'h0000);
    repeat (4) begin
      c = (rng[7:0] == 8'h8c) ? 8'h00 : rng[7:0];
      rng = xs(rng);
      wr(fppt_pkg::ADDR_CMD, fppt_pkg::CMD_UNLOCK1, 1'b0);
      wr(fppt_pkg::ADDR_CMD, c, 1'b0);
      rd(fppt_pkg::ADDR_CMD);
      check(rd_val, 16'h0000);
    end
    // the operation's own initiator loads page select before each operation
    foreach (OPS[i]) begin
      page_m = OPS[i][25:18];
      wr(fppt_pkg::ADDR_PAGE, page_m, OPS[i][16]);
      rd(fppt_pkg::ADDR_PAGE);
      check(rd_val, page_m);
      run_op(OPS[i][17], OPS[i][16], OPS[i][15:0]);
    end
    complete_run();
  end
endmodule // flash_page_protect_timing_tb
